/* rtl/lamp_inverter_regs.svh */
// Constants of the lamp inverter supervisor: timing figures and derived cycle counts.
// Notes on behaviour
// - Reaching the run frequency after ignition starts a 625 ms pre-run phase that then goes to run.
// - Both end-of-life detectors stay disabled during pre-run and are enabled only in run.
// - An AC lamp sense current above 210 uA pp held for more than 620 us is a lamp overvoltage fault.
// - A lamp overvoltage fault restarts once, then latches power down until the fault goes away.
// - A DC lamp sense current above 42 uA of either sign held for 2500 ms is a rectifier fault.
// - A rectifier fault restarts once, then latches power down until a new lamp is detected.
// - In run, low-side sense below +100 mV over the second half of low-side on-time means idling.
// - Idling held for 2500 ms restarts once, then latches power down until a load is back.
// - Low-side sense below -100 mV before high-side turn-on or above 2.0 V at it means overcurrent.
// - Overcurrent held for 620 us restarts once, then latches power down until both overcurrent sense flags are gone.
// - The dead time adapts within 1.25 us to 2.5 us and is applied in every mode except latched power down.
// - Dead time measurement starts when the high-side gate is switched off.
// - Measurement ends after sense stays below -100 mV for 280 ns; the time is stored, low side on.
// - After the low-side gate turns off the stored dead time elapses before high side turns on.
`ifndef LAMP_INVERTER_REGS_SVH
`define LAMP_INVERTER_REGS_SVH
`define LIF_CLK_MHZ 125
`define LIF_PRERUN_MS 625
`define LIF_OV_US 620
`define LIF_RECT_MS 2500
`define LIF_IDLE_MS 2500
`define LIF_OC_US 620
`define LIF_DT_MIN_NS 1250
`define LIF_DT_MAX_NS 2500
`define LIF_FILT_NS 280
`define LIF_MS_CYC(ms) ((ms) * `LIF_CLK_MHZ * 1000)
`define LIF_US_CYC(us) ((us) * `LIF_CLK_MHZ)
`define LIF_NS_CEIL(ns) (((ns) * `LIF_CLK_MHZ + 999) / 1000)
`define LIF_NS_FLOOR(ns) (((ns) * `LIF_CLK_MHZ) / 1000)
`define LIF_F_OV 0
`define LIF_F_RECT 1
`define LIF_F_IDLE 2
`define LIF_F_OC 3
`endif

/* rtl/lamp_inverter_pkg.sv */
// Types shared by the lamp inverter supervisor and its users.
package lamp_inverter_pkg;
    typedef enum logic [3:0] {
        MODE_START = 4'h1,
        MODE_PRERUN = 4'h2,
        MODE_RUN = 4'h4,
        MODE_LATCHED = 4'h8
    } mode_type;
    typedef struct packed {
        logic ac_over;
        logic dc_over;
    } lamp_voltage_sense_type;
    typedef struct packed {
        logic below_p100;
        logic below_m100;
        logic above_2v;
    } low_side_current_sense_type;
    typedef struct packed {
        logic overcurrent_load_fault;
        logic idle_load_fault;
        logic rectifier_effect_fault;
        logic lamp_overvoltage_fault;
    } fault_vec_type;
endpackage

/* rtl/lamp_inverter_fault_deadtime.sv */
// Lamp inverter supervisor: end-of-life and load faults with restart, and adaptive dead time.
`timescale 1ns/10ps
`include "lamp_inverter_regs.svh"
module lamp_inverter_fault_deadtime #(
    parameter int PRERUN_CYC = `LIF_MS_CYC(`LIF_PRERUN_MS),
    parameter int OV_CYC = `LIF_US_CYC(`LIF_OV_US),
    parameter int RECT_CYC = `LIF_MS_CYC(`LIF_RECT_MS),
    parameter int IDLE_CYC = `LIF_MS_CYC(`LIF_IDLE_MS),
    parameter int OC_CYC = `LIF_US_CYC(`LIF_OC_US),
    parameter int HS_WIN_CYC = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic run_freq_reached,
    input wire logic lamp_inserted,
    input wire logic hs_off_req,
    input wire logic ls_off_req,
    input wire lamp_inverter_pkg::lamp_voltage_sense_type lamp_voltage_sense,
    input wire lamp_inverter_pkg::low_side_current_sense_type low_side_current_sense,
    output logic gate_hs,
    output logic gate_ls,
    output lamp_inverter_pkg::mode_type mode,
    output logic eol_enable,
    output logic restart_req,
    output logic power_down,
    output lamp_inverter_pkg::fault_vec_type fault_seen,
    output logic [8:0] stored_dead_time
);
    import lamp_inverter_pkg::*;

    // ----------------------------------------------------------------
    // Derived dead-time figures
    // ----------------------------------------------------------------
    localparam logic [8:0] DT_MIN = 9'(`LIF_NS_CEIL(`LIF_DT_MIN_NS));
    localparam logic [8:0] DT_MAX = 9'(`LIF_NS_FLOOR(`LIF_DT_MAX_NS));
    localparam logic [8:0] FILT = 9'(`LIF_NS_CEIL(`LIF_FILT_NS));

    if (PRERUN_CYC < 1 || OV_CYC < 1 || RECT_CYC < 1 || IDLE_CYC < 1 || OC_CYC < 1) begin : g_chk
        $error("Persistence counts must be at least one cycle.");
    end
    if (HS_WIN_CYC < 1 || HS_WIN_CYC > 255) begin : g_chk_win
        $error("High-side window must be 1 to 255 cycles.");
    end

    // Timer reaches its limit; shared by all persistence timers.
    function automatic logic reached(input logic [31:0] cnt, input int lim);
        reached = (cnt >= 32'(lim - 1));
    endfunction

    // ----------------------------------------------------------------
    // Half-bridge sequencing
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        HB_HS_ON = 4'h1,
        HB_MEAS = 4'h2,
        HB_LS_ON = 4'h4,
        HB_WAIT = 4'h8
    } hb_type;

    hb_type hb_reg;
    logic [8:0] dt_cnt_reg;
    logic [8:0] filt_cnt_reg;
    logic [15:0] ls_cnt_reg;
    logic [15:0] ls_len_reg;
    logic [7:0] hs_win_reg;
    logic active;
    logic meas_done;
    logic wait_done;

    assign active = (mode != MODE_LATCHED);
    assign meas_done = (filt_cnt_reg >= FILT - 9'h001) && low_side_current_sense.below_m100;
    assign wait_done = (dt_cnt_reg >= stored_dead_time - 9'h001);

    // Dead time runs in every mode except latched power down, which parks both gates.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            hb_reg <= HB_WAIT;
            dt_cnt_reg <= 9'h000;
        end else if (!active) begin
            hb_reg <= HB_WAIT;
            dt_cnt_reg <= 9'h000;
        end else begin
            case (hb_reg)
                HB_HS_ON: begin
                    dt_cnt_reg <= 9'h000;
                    if (hs_off_req) begin
                        hb_reg <= HB_MEAS;
                    end
                end
                HB_MEAS: begin
                    dt_cnt_reg <= dt_cnt_reg + 9'h001;
                    // A missing sense edge must not stall the bridge, so the maximum ends it too.
                    if (meas_done || dt_cnt_reg >= DT_MAX - 9'h001) begin
                        hb_reg <= HB_LS_ON;
                    end
                end
                HB_LS_ON: begin
                    dt_cnt_reg <= 9'h000;
                    if (ls_off_req) begin
                        hb_reg <= HB_WAIT;
                    end
                end
                default: begin
                    dt_cnt_reg <= dt_cnt_reg + 9'h001;
                    if (wait_done) begin
                        hb_reg <= HB_HS_ON;
                    end
                end
            endcase
        end
    end

    // The low-side sense must stay below -100 mV without a break to close a measurement.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            filt_cnt_reg <= 9'h000;
        end else if (hb_reg == HB_MEAS && low_side_current_sense.below_m100) begin
            filt_cnt_reg <= filt_cnt_reg + 9'h001;
        end else begin
            filt_cnt_reg <= 9'h000;
        end
    end

    // Store the measured time, clamped into the adjustable range.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            stored_dead_time <= DT_MAX;
        end else if (hb_reg == HB_MEAS && (meas_done || dt_cnt_reg >= DT_MAX - 9'h001)) begin
            if (dt_cnt_reg + 9'h001 < DT_MIN) begin
                stored_dead_time <= DT_MIN;
            end else begin
                stored_dead_time <= dt_cnt_reg + 9'h001;
            end
        end
    end

    // Gates come from flip-flops so they never glitch on decoder transitions.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            gate_hs <= 1'b0;
            gate_ls <= 1'b0;
        end else begin
            gate_hs <= active && (hb_reg == HB_HS_ON) && !hs_off_req;
            gate_ls <= active && (hb_reg == HB_LS_ON) && !ls_off_req;
        end
    end

    // ----------------------------------------------------------------
    // Load condition sampling on the low-side sense
    // ----------------------------------------------------------------
    logic idle_ok_reg;
    logic idle_cond_reg;
    logic oc_cond_reg;
    logic pre_hs_low;

    // The previous on-time gives the half point; the first period after reset uses zero.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ls_cnt_reg <= 16'h0000;
            ls_len_reg <= 16'h0000;
        end else if (hb_reg == HB_LS_ON) begin
            ls_cnt_reg <= ls_cnt_reg + 16'h0001;
            if (ls_off_req) begin
                ls_len_reg <= ls_cnt_reg + 16'h0001;
            end
        end else begin
            ls_cnt_reg <= 16'h0000;
        end
    end

    // Idling holds only if the sense stayed under +100 mV over the whole second half.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            idle_ok_reg <= 1'b1;
            idle_cond_reg <= 1'b0;
        end else if (hb_reg == HB_LS_ON) begin
            if (ls_cnt_reg >= {1'b0, ls_len_reg[15:1]} && !low_side_current_sense.below_p100) begin
                idle_ok_reg <= 1'b0;
            end
            if (ls_off_req) begin
                idle_cond_reg <= idle_ok_reg && low_side_current_sense.below_p100;
            end
        end else begin
            idle_ok_reg <= 1'b1;
            idle_cond_reg <= idle_cond_reg && active;
        end
    end

    assign pre_hs_low = (hb_reg == HB_WAIT) && wait_done && low_side_current_sense.below_m100;
    // Overcurrent is judged once per period; a parked bridge drops any old verdict.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            hs_win_reg <= 8'h00;
            oc_cond_reg <= 1'b0;
        end else if (pre_hs_low) begin
            oc_cond_reg <= 1'b1;
            hs_win_reg <= 8'(HS_WIN_CYC);
        end else if ((hb_reg == HB_WAIT && wait_done) || !active) begin
            oc_cond_reg <= 1'b0;
            hs_win_reg <= active ? 8'(HS_WIN_CYC) : 8'h00;
        end else if (hs_win_reg != 8'h00) begin
            hs_win_reg <= hs_win_reg - 8'h01;
            if (low_side_current_sense.above_2v) begin
                oc_cond_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Persistence timers, one for each fault
    // ----------------------------------------------------------------
    logic [3:0] cond;
    logic [3:0] qual;
    logic [31:0] pers_reg [4];
    int lim [4];

    assign lim[`LIF_F_OV] = OV_CYC;
    assign lim[`LIF_F_RECT] = RECT_CYC;
    assign lim[`LIF_F_IDLE] = IDLE_CYC;
    assign lim[`LIF_F_OC] = OC_CYC;

    // Nothing is watched outside run mode, which keeps the pre-run phase fault free.
    always_comb begin
        cond[`LIF_F_OV] = eol_enable && lamp_voltage_sense.ac_over;
        cond[`LIF_F_RECT] = eol_enable && lamp_voltage_sense.dc_over;
        cond[`LIF_F_IDLE] = (mode == MODE_RUN) && idle_cond_reg;
        cond[`LIF_F_OC] = (mode == MODE_RUN) && oc_cond_reg;
    end

    for (genvar i = 0; i < 4; i++) begin : g_pers
        assign qual[i] = cond[i] && reached(pers_reg[i], lim[i]);
        // Any drop-out sends the timer back to zero, so only an unbroken condition qualifies.
        always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
                pers_reg[i] <= 32'h0000_0000;
            end else if (!cond[i] || qual[i]) begin
                pers_reg[i] <= 32'h0000_0000;
            end else begin
                pers_reg[i] <= pers_reg[i] + 32'h0000_0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Operating mode and restart handling
    // ----------------------------------------------------------------
    logic [31:0] prerun_reg;
    logic [3:0] used_reg;
    logic [3:0] latch_src_reg;
    logic [3:0] clear;
    logic any_qual;
    logic repeat_qual;
    logic released;

    assign any_qual = |qual;
    assign repeat_qual = |(qual & used_reg);
    assign eol_enable = (mode == MODE_RUN);
    assign power_down = (mode == MODE_LATCHED);

    // Clearance of each latched fault as seen by the sensing network.
    always_comb begin
        clear[`LIF_F_OV] = !lamp_voltage_sense.ac_over;
        clear[`LIF_F_RECT] = lamp_inserted;
        clear[`LIF_F_IDLE] = !low_side_current_sense.below_p100;
        clear[`LIF_F_OC] = !low_side_current_sense.below_m100 &&
            !low_side_current_sense.above_2v;
    end

    assign released = ((latch_src_reg & ~clear) == 4'h0);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            mode <= MODE_START;
            prerun_reg <= 32'h0000_0000;
        end else begin
            case (mode)
                MODE_START: begin
                    prerun_reg <= 32'h0000_0000;
                    if (run_freq_reached) begin
                        mode <= MODE_PRERUN;
                    end
                end
                MODE_PRERUN: begin
                    prerun_reg <= prerun_reg + 32'h0000_0001;
                    if (reached(prerun_reg, PRERUN_CYC)) begin
                        mode <= MODE_RUN;
                    end
                end
                MODE_RUN: begin
                    if (repeat_qual) begin
                        mode <= MODE_LATCHED;
                    end else if (any_qual) begin
                        mode <= MODE_START;
                    end
                end
                default: begin
                    if (released) begin
                        mode <= MODE_START;
                    end
                end
            endcase
        end
    end

    // A restart pulse goes out on a first fault and when a latched fault releases.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            restart_req <= 1'b0;
        end else begin
            restart_req <= ((mode == MODE_RUN) && any_qual && !repeat_qual) ||
                ((mode == MODE_LATCHED) && released);
        end
    end

    // Restart-used bits; a bit is freed only by the clearance of a latched fault.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            used_reg <= 4'h0;
            latch_src_reg <= 4'h0;
        end else if (mode == MODE_RUN && any_qual) begin
            used_reg <= used_reg | qual;
            if (repeat_qual) begin
                latch_src_reg <= qual & used_reg;
            end
        end else if (mode == MODE_LATCHED && released) begin
            used_reg <= used_reg & ~latch_src_reg;
            latch_src_reg <= 4'h0;
        end
    end

    // Sticky record of faults that qualified, cleared together with their restart bit.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_seen <= '0;
        end else begin
            fault_seen <= (fault_seen & ~((mode == MODE_LATCHED && released) ?
                latch_src_reg : 4'h0)) | qual;
        end
    end
endmodule

/* tb/lamp_partner.sv */
// Far-side model: low-side current sense comparators reacting to the bridge gates.
`timescale 1ns/10ps
module lamp_partner (
    input logic mclk,
    input logic sys_rst,
    input logic gate_hs,
    input logic gate_ls,
    input int dt_delay,
    input logic no_load,
    input logic overcurrent,
    output lamp_inverter_pkg::low_side_current_sense_type low_side_current_sense
);
    import lamp_inverter_pkg::*;
    int since_hs_reg;
    logic armed_reg;
    // --------------------------------------------------------------
    // Freewheel timing
    // --------------------------------------------------------------
    // The window closes after a while, so a stopped bridge reads quiet.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            since_hs_reg <= 0;
            armed_reg <= 1'b0;
        end else begin
            since_hs_reg <= gate_hs ? 0 : since_hs_reg + int'(since_hs_reg < 100000);
            armed_reg <= gate_hs | (armed_reg & !gate_ls);
        end
    end
    // An overcurrent pulls the sense negative and holds it above 2 V while the high side is on.
    assign low_side_current_sense.below_m100 = overcurrent || (armed_reg && !gate_ls &&
        since_hs_reg >= dt_delay && since_hs_reg < dt_delay + 40);
    assign low_side_current_sense.below_p100 = no_load;
    assign low_side_current_sense.above_2v = overcurrent && gate_hs;
endmodule

/* tb/lamp_inverter_asserts.sv */
// Port-level checks of the lamp inverter supervisor, bound into the design.
`timescale 1ns/10ps
module lamp_inverter_asserts
    import lamp_inverter_pkg::*;
#(
    parameter int PRERUN_CYC = 20,
    parameter int OV_CYC = 10,
    parameter int RECT_CYC = 10
) (
    input logic mclk,
    input logic sys_rst,
    input lamp_inverter_pkg::lamp_voltage_sense_type lamp_voltage_sense,
    input logic gate_hs,
    input logic gate_ls,
    input lamp_inverter_pkg::mode_type mode,
    input logic eol_enable,
    input logic restart_req,
    input logic power_down,
    input logic [8:0] stored_dead_time
);
    int prerun_cnt_reg;
    int ov_cnt_reg;
    int rect_cnt_reg;
    logic ov_cond;
    logic rect_cond;
    assign ov_cond = eol_enable && lamp_voltage_sense.ac_over;
    assign rect_cond = eol_enable && lamp_voltage_sense.dc_over;
    // --------------------------------------------------------------
    // Run lengths of pre-run and of each end-of-life condition
    // --------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prerun_cnt_reg <= 0;
            ov_cnt_reg <= 0;
            rect_cnt_reg <= 0;
        end else begin
            prerun_cnt_reg <= (mode == MODE_PRERUN) ? prerun_cnt_reg + 1 : 0;
            ov_cnt_reg <= ov_cond ? ov_cnt_reg + 1 : 0;
            rect_cnt_reg <= rect_cond ? rect_cnt_reg + 1 : 0;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_hs_drop; $fell(gate_hs); endsequence
    sequence s_ls_quiet; !gate_ls [*8]; endsequence
    sequence s_restart_step; mode == MODE_START ##1 !restart_req; endsequence
    property p_prerun_len; mode == MODE_PRERUN |-> prerun_cnt_reg <= PRERUN_CYC; endproperty
    a_prerun_len: assert property (p_prerun_len) else $error("pre-run too long");
    property p_prerun_exit;
        $past(mode) == MODE_PRERUN && mode != MODE_PRERUN |-> mode == MODE_RUN;
    endproperty
    a_prerun_exit: assert property (p_prerun_exit) else $error("pre-run left wrongly");
    property p_eol_gate; !eol_enable && !power_down |=> !restart_req; endproperty
    a_eol_gate: assert property (p_eol_gate) else $error("fault outside run");
    property p_ov_qual; ov_cnt_reg == OV_CYC - 1 && ov_cond |=> restart_req || power_down;
    endproperty
    a_ov_qual: assert property (p_ov_qual) else $error("overvoltage missed");
    property p_rect_qual; rect_cnt_reg == RECT_CYC - 1 && rect_cond |=> restart_req || power_down;
    endproperty
    a_rect_qual: assert property (p_rect_qual) else $error("rectifier missed");
    property p_latched_off; power_down && $past(power_down) |-> !gate_hs && !gate_ls; endproperty
    a_latched_off: assert property (p_latched_off) else $error("gates on");
    property p_restart_step; restart_req |-> s_restart_step; endproperty
    a_restart_step: assert property (p_restart_step) else $error("bad restart");
    property p_no_overlap; !(gate_hs && gate_ls); endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("both gates on");
    property p_dt_range; stored_dead_time >= 9'h09d && stored_dead_time <= 9'h138; endproperty
    a_dt_range: assert property (p_dt_range) else $error("dead time range");
    property p_ls_after_hs; s_hs_drop |-> s_ls_quiet; endproperty
    a_ls_after_hs: assert property (p_ls_after_hs) else $error("low side early");
    property p_hs_after_ls; $fell(gate_ls) |-> !gate_hs [*8]; endproperty
    a_hs_after_ls: assert property (p_hs_after_ls) else $error("high side early");
endmodule
bind lamp_inverter_fault_deadtime lamp_inverter_asserts #(
    .PRERUN_CYC(PRERUN_CYC),
    .OV_CYC(OV_CYC),
    .RECT_CYC(RECT_CYC)
) u_asserts (
    .mclk(mclk), .sys_rst(sys_rst), .lamp_voltage_sense(lamp_voltage_sense),
    .gate_hs(gate_hs), .gate_ls(gate_ls), .mode(mode), .eol_enable(eol_enable),
    .restart_req(restart_req), .power_down(power_down), .stored_dead_time(stored_dead_time)
);

/* tb/tb_top.sv */
// Self-checking bench for the lamp inverter supervisor.
`timescale 1ns/10ps
module tb_top;
    import lamp_inverter_pkg::*;
    localparam int PRE = 20;
    localparam int LIM = 10;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic run_freq_reached = 1'b0;
    logic lamp_inserted = 1'b0;
    logic hs_off_req = 1'b0;
    logic ls_off_req = 1'b0;
    logic [3:0] cond = 4'h0;
    logic [31:0] lfsr_reg = 32'hc29f;
    int dt_delay = 1;
    int on_cnt = 0;
    int on_len = 40;
    int failures = 0;
    int comparisons = 0;
    int dts[3] = '{1, 200, 2000};
    lamp_voltage_sense_type lamp_voltage_sense;
    low_side_current_sense_type low_side_current_sense;
    logic gate_hs, gate_ls, eol_enable, restart_req, power_down;
    mode_type mode;
    fault_vec_type fault_seen;
    logic [3:0] seen_bits;
    logic [8:0] stored_dead_time;
    assign lamp_voltage_sense = {cond[0], cond[1]};
    assign seen_bits = fault_seen;
    lamp_inverter_fault_deadtime #(.PRERUN_CYC(PRE), .OV_CYC(LIM), .RECT_CYC(LIM),
        .IDLE_CYC(LIM), .OC_CYC(LIM), .HS_WIN_CYC(8)) dut (
        .mclk(mclk), .sys_rst(sys_rst), .run_freq_reached(run_freq_reached),
        .lamp_inserted(lamp_inserted), .hs_off_req(hs_off_req), .ls_off_req(ls_off_req),
        .lamp_voltage_sense(lamp_voltage_sense), .low_side_current_sense(low_side_current_sense),
        .gate_hs(gate_hs), .gate_ls(gate_ls), .mode(mode), .eol_enable(eol_enable),
        .restart_req(restart_req), .power_down(power_down), .fault_seen(fault_seen),
        .stored_dead_time(stored_dead_time));
    lamp_partner u_partner (.mclk(mclk), .sys_rst(sys_rst), .gate_hs(gate_hs),
        .gate_ls(gate_ls), .dt_delay(dt_delay), .no_load(cond[2]), .overcurrent(cond[3]),
        .low_side_current_sense(low_side_current_sense));
    // --------------------------------------------------------------
    // Clock, random source and frequency generator
    // --------------------------------------------------------------
    always #4 mclk = ~mclk;
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Ends each gate's on-time after a random length, one request pulse per gate.
    always @(posedge mclk) begin
        hs_off_req <= 1'b0;
        ls_off_req <= 1'b0;
        on_cnt <= 0;
        if ((gate_hs || gate_ls) && !hs_off_req && !ls_off_req) begin
            on_cnt <= on_cnt + 1;
            if (on_cnt >= on_len) begin
                hs_off_req <= gate_hs;
                ls_off_req <= gate_ls;
                on_cnt <= 0;
                lfsr_reg <= lfsr_next(lfsr_reg);
                on_len <= 20 + int'(lfsr_reg[5:0]);
            end
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    function automatic logic hit(input int sel);
        case (sel)
            0: return mode == MODE_RUN;
            1: return restart_req;
            2: return power_down;
            3: return gate_ls;
            4: return gate_hs;
            default: return ls_off_req;
        endcase
    endfunction
    // Every wait is bounded; running out ends the run as a failure.
    task automatic wait_for(input int sel, input int bound, output int n);
        n = 0;
        while (hit(sel) !== 1'b1) begin
            @(posedge mclk);
            #1;
            n++;
            if (n > bound) begin
                failures++;
                final_report();
            end
        end
    endtask
    // Pre-run entry; a glitch raises the AC flag in start and pre-run, never in run.
    task automatic go_run(input logic glitch);
        int n;
        int skip;
        skip = glitch ? PRE - 6 : 0;
        @(posedge mclk);
        run_freq_reached <= 1'b1;
        lamp_inserted <= 1'b0;
        if (glitch) cond[0] <= 1'b1;
        @(posedge mclk);
        run_freq_reached <= 1'b0;
        #1 check(mode, MODE_PRERUN);
        check(eol_enable, 32'h0);
        repeat (skip) @(posedge mclk);
        if (glitch) cond[0] <= 1'b0;
        wait_for(0, PRE + 5, n);
        check(n + skip >= PRE - 1 && n + skip <= PRE + 1, 32'h1);
        check(eol_enable, 32'h1);
    endtask
    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        int n;
        int f;
        int i;
        int ex;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        #1 check(mode, MODE_START);
        check(stored_dead_time, 9'h138);
        check(fault_seen, 4'h0);
        for (i = 0; i < 3; i++) begin
            dt_delay <= dts[i];
            wait_for(4, 700, n);
            wait_for(3, 700, n);
            ex = dts[i] + 35;
            if (ex <= 157 || ex >= 312) check(stored_dead_time, ex <= 157 ? 157 : 312);
            else check(stored_dead_time >= ex - 3 && stored_dead_time <= ex + 3, 32'h1);
            ex = stored_dead_time;
            wait_for(5, 200, n);
            wait_for(4, 700, n);
            check(n >= ex && n <= ex + 3, 32'h1);
        end
        dt_delay <= 1;
        go_run(1'b1);
        check(fault_seen, 4'h0);
        for (i = 0; i < 4; i++) begin
            @(posedge mclk);
            cond[0] <= 1'b1;
            repeat (1 + int'(lfsr_reg[3:0]) % (LIM - 1)) @(posedge mclk);
            cond[0] <= 1'b0;
        end
        @(posedge mclk);
        #1 check(fault_seen, 4'h0);
        check(mode, MODE_RUN);
        for (f = 0; f < 4; f++) begin
            @(posedge mclk);
            cond[f] <= 1'b1;
            wait_for(1, 2000, n);
            check(seen_bits[f], 32'h1);
            check(mode, MODE_START);
            go_run(1'b0);
            wait_for(2, 2000, n);
            check(mode, MODE_LATCHED);
            repeat (3) @(posedge mclk);
            #1 check({gate_hs, gate_ls}, 32'h0);
            @(posedge mclk);
            cond[f] <= 1'b0;
            if (f == 1) begin
                repeat (30) @(posedge mclk);
                #1 check(mode, MODE_LATCHED);
                @(posedge mclk);
                lamp_inserted <= 1'b1;
            end
            wait_for(1, 1000, n);
            check(mode, MODE_START);
            check(seen_bits[f], 32'h0);
            if (f < 3) go_run(1'b0);
        end
        final_report();
    end
endmodule
